// >>> slt_pkg.sv
// Purpose: constants for link, response and time-to-live timers and error capture
// Assumes: 100 MHz clk_sys; register offsets are byte addresses
// Notes:   bit positions given as lsb-zero indices
package slt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned NUM_SRC       = 2;
  localparam int unsigned NUM_LINK_EV   = 2;
  localparam int unsigned SRC_MSG_UNIT  = 1;

  // clock dividers, in platform clock periods per count step
  localparam int unsigned LINK_DIV_CLKS = 2;
  localparam int unsigned RESP_DIV_CLKS = 60;
  localparam int unsigned TTL_DIV_CLKS  = 2;
  localparam logic [5:0]  RESP_PRE_LAST = 6'(RESP_DIV_CLKS - 1);

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_LINK_TIMEOUT  = 24'h000120;
  localparam logic [ADDR_W-1:0] OFS_RESP_TIMEOUT  = 24'h000124;
  localparam logic [ADDR_W-1:0] OFS_GEN_CTRL      = 24'h00013C;
  localparam logic [ADDR_W-1:0] OFS_LOCAL_ACK     = 24'h000148;
  localparam logic [ADDR_W-1:0] OFS_ERR_DETECT    = 24'h000608;
  localparam logic [ADDR_W-1:0] OFS_ERR_ENABLE    = 24'h00060C;
  localparam logic [ADDR_W-1:0] OFS_PW_INT_STATUS = 24'h1D0124;
  localparam logic [ADDR_W-1:0] OFS_ACCEPT_ALL    = 24'h1D0138;
  localparam logic [ADDR_W-1:0] OFS_TTL_CONFIG    = 24'h1D013C;
  localparam logic [ADDR_W-1:0] OFS_PHY_LINK_CFG  = 24'h1D0140;
  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] OFS_CAP_ADDR  = {24'h000714, 24'h000614};
  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] OFS_CAP_DEVID = {24'h000718, 24'h000618};
  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] OFS_CAP_CTRL  = {24'h00071C, 24'h00061C};
  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] OFS_CAP_EXT   = {24'h000740, 24'h000640};

  // field positions (lsb-zero)
  localparam int unsigned TO_VAL_LSB       = 8;
  localparam int unsigned ILLEGAL_TGT_BIT  = 26;
  localparam int unsigned RESP_TO_FLAG_BIT = 24;
  localparam int unsigned PW_PENDING_BIT   = 31;
  localparam int unsigned OB_DRAIN_BIT     = 2;
  localparam int unsigned PHY_CFG_FLAG_BIT = 4;
  localparam int unsigned ECI_LSB          = 8;
  localparam int unsigned ACK_OUT_LSB      = 0;
  localparam int unsigned ACK_IN_LSB       = 24;
  localparam int unsigned ACK_W            = 5;

  // register masks and reset values
  localparam logic [31:0] GEN_CTRL_MASK    = 32'hE0000000;
  localparam logic [31:0] ERR_DETECT_MASK  = 32'hFF0000FF;
  localparam logic [31:0] PHY_CFG_MASK     = 32'h0000003C;
  localparam logic [31:0] PW_STATUS_MASK   = 32'h80000000;
  localparam logic [CNT_W-1:0] TO_RESET    = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] TTL_RESET   = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 24'h000001;
  localparam logic [31:0] ACCEPT_ALL_RESET = 32'h10000000;
  localparam logic [31:0] PHY_CFG_RESET    = 32'h00000010;
  localparam logic [31:0] ZERO32           = 32'h00000000;
endpackage : slt_pkg

// >>> slt_timeouts.sv
// Purpose: link, response and time-to-live timers with lock-once error capture
// Assumes: all event inputs are one-cycle pulses synchronous to clk_sys
// Notes:   index 0 of capture arrays is the port, index 1 the message unit
`timescale 1ns/1ps
module slt_timeouts (
  input  wire logic                                       clk_sys,
  input  wire logic                                       srst,
  input  wire logic [slt_pkg::ADDR_W-1:0]                 reg_addr,
  input  wire logic [31:0]                                reg_wdata,
  input  wire logic                                       reg_wr,
  input  wire logic                                       reg_rd,
  output logic      [31:0]                                reg_rdata,
  input  wire logic                                       pkt_sent,
  input  wire logic                                       ack_rcvd,
  input  wire logic                                       link_req_sent,
  input  wire logic                                       link_resp_rcvd,
  input  wire logic                                       req_sent,
  input  wire logic                                       resp_rcvd,
  input  wire logic                                       pkt_ready,
  input  wire logic                                       pkt_accept,
  input  wire logic                                       pkt_needs_resp,
  input  wire logic                                       doorbell_resp_timeout,
  input  wire logic                                       rx_bad_destid,
  input  wire logic [slt_pkg::ACK_W-1:0]                  tx_ackid,
  input  wire logic [slt_pkg::ACK_W-1:0]                  rx_ackid,
  input  wire logic [slt_pkg::NUM_SRC-1:0]                err_event,
  input  wire logic [slt_pkg::NUM_SRC-1:0][31:0]          err_addr,
  input  wire logic [slt_pkg::NUM_SRC-1:0][31:0]          err_devid,
  input  wire logic [slt_pkg::NUM_SRC-1:0][31:0]          err_ctrl,
  input  wire logic [slt_pkg::NUM_SRC-1:0][15:0]          err_char_is_ctrl,
  output logic      [slt_pkg::NUM_LINK_EV-1:0]            link_timeout,
  output logic                                            resp_timeout,
  output logic                                            ttl_discard,
  output logic                                            internal_err_resp,
  output logic                                            outbound_drain_enable,
  output logic      [slt_pkg::NUM_SRC-1:0]                capture_locked,
  output logic      [31:0]                                ext_ack_status
);
  import slt_pkg::*;

  typedef struct packed {
    logic [31:0]                         rdata;
    logic [CNT_W-1:0]                    lto_val;
    logic [CNT_W-1:0]                    rto_val;
    logic [CNT_W-1:0]                    ttl_val;
    logic [31:0]                         gcs;
    logic [31:0]                         accept_all_configuration;
    logic [31:0]                         physical_link_configuration;
    logic [31:0]                         led;
    logic [31:0]                         lee;
    logic [31:0]                         pwis;
    logic [NUM_LINK_EV-1:0]              lt_act;
    logic [NUM_LINK_EV-1:0][CNT_W-1:0]   lt_cnt;
    logic                                rt_act;
    logic [CNT_W-1:0]                    rt_cnt;
    logic                                ttl_act;
    logic                                ttl_resp;
    logic [CNT_W-1:0]                    ttl_cnt;
    logic                                ie_act;
    logic [CNT_W-1:0]                    ie_cnt;
    logic                                half;
    logic [5:0]                          pre;
    logic [NUM_SRC-1:0]                  lock;
    logic [NUM_SRC-1:0][31:0]            cap_addr;
    logic [NUM_SRC-1:0][31:0]            cap_devid;
    logic [NUM_SRC-1:0][31:0]            cap_ctrl;
    logic [NUM_SRC-1:0][15:0]            cap_eci;
    logic [NUM_LINK_EV-1:0]              lt_exp;
    logic                                rt_exp;
    logic                                ttl_exp;
    logic                                ie_exp;
    logic [31:0]                         ack;
  } slt_state_type;

  slt_state_type state;
  slt_state_type next_state;

  logic                    tick_link;
  logic                    tick_resp;
  logic [NUM_LINK_EV-1:0]  lt_start;
  logic [NUM_LINK_EV-1:0]  lt_stop;
  logic [31:0]             wr_lto;
  logic [31:0]             rd_val;
  logic                    lock_any;

  assign lt_start = {link_req_sent, pkt_sent};
  assign lt_stop  = {link_resp_rcvd, ack_rcvd};
  assign tick_link = state.half;
  assign tick_resp = (state.pre == RESP_PRE_LAST);
  assign lock_any  = |state.lock;

  always_comb begin
    next_state = state;
    wr_lto     = ZERO32;
    rd_val     = ZERO32;
    next_state.lt_exp  = '0;
    next_state.rt_exp  = 1'b0;
    next_state.ttl_exp = 1'b0;
    next_state.ie_exp  = 1'b0;

    // dividers
    next_state.half = ~state.half;
    next_state.pre  = tick_resp ? 6'h00 : state.pre + 6'h01;

    // link timers, one per awaited event, sharing one value
    for (int i = 0; i < NUM_LINK_EV; i++) begin
      if (lt_start[i]) begin
        next_state.lt_act[i] = 1'b1;
        next_state.lt_cnt[i] = state.lto_val;
      end else if (lt_stop[i]) begin
        next_state.lt_act[i] = 1'b0;
      end else if (state.lt_act[i] && tick_link) begin
        if (state.lt_cnt[i] == CNT_ZERO) begin
          next_state.lt_act[i] = 1'b0;
          next_state.lt_exp[i] = 1'b1;
        end else begin
          next_state.lt_cnt[i] = state.lt_cnt[i] - CNT_ONE;
        end
      end
    end

    // response timer
    if (req_sent) begin
      next_state.rt_act = 1'b1;
      next_state.rt_cnt = state.rto_val;
    end else if (resp_rcvd) begin
      next_state.rt_act = 1'b0;
    end else if (state.rt_act && tick_resp) begin
      if (state.rt_cnt == CNT_ZERO) begin
        next_state.rt_act = 1'b0;
        next_state.rt_exp = 1'b1;
      end else begin
        next_state.rt_cnt = state.rt_cnt - CNT_ONE;
      end
    end

    // time-to-live, zero value disables it
    if (pkt_ready && (state.ttl_val != CNT_ZERO)) begin
      next_state.ttl_act  = 1'b1;
      next_state.ttl_cnt  = state.ttl_val;
      next_state.ttl_resp = pkt_needs_resp;
    end else if (pkt_accept) begin
      next_state.ttl_act = 1'b0;
    end else if (state.ttl_act && tick_link) begin
      if (state.ttl_cnt == CNT_ZERO) begin
        next_state.ttl_act = 1'b0;
        next_state.ttl_exp = 1'b1;
        if (state.ttl_resp) begin
          next_state.ie_act = 1'b1;
          next_state.ie_cnt = state.rto_val;
        end
      end else begin
        next_state.ttl_cnt = state.ttl_cnt - CNT_ONE;
      end
    end

    // internal error response once the response time-out elapses
    if (state.ie_act && tick_resp) begin
      if (state.ie_cnt == CNT_ZERO) begin
        next_state.ie_act = 1'b0;
        next_state.ie_exp = 1'b1;
      end else begin
        next_state.ie_cnt = state.ie_cnt - CNT_ONE;
      end
    end

    // ack status mirror for local and external readers
    next_state.ack = ZERO32;
    next_state.ack[ACK_IN_LSB +: ACK_W]  = rx_ackid;
    next_state.ack[ACK_OUT_LSB +: ACK_W] = tx_ackid;

    // register writes
    if (reg_wr) begin
      wr_lto = reg_wdata;
      unique case (reg_addr)
        OFS_LINK_TIMEOUT: next_state.lto_val = wr_lto[TO_VAL_LSB +: CNT_W];
        OFS_RESP_TIMEOUT: next_state.rto_val = wr_lto[TO_VAL_LSB +: CNT_W];
        OFS_TTL_CONFIG:   next_state.ttl_val = wr_lto[TO_VAL_LSB +: CNT_W];
        OFS_GEN_CTRL:     next_state.gcs = reg_wdata & GEN_CTRL_MASK;
        OFS_ACCEPT_ALL:   next_state.accept_all_configuration = reg_wdata;
        OFS_PHY_LINK_CFG: next_state.physical_link_configuration = reg_wdata & PHY_CFG_MASK;
        OFS_ERR_ENABLE:   next_state.lee = reg_wdata & ERR_DETECT_MASK;
        OFS_ERR_DETECT: begin
          next_state.led  = state.led & reg_wdata;
          if (reg_wdata == ZERO32) begin
            next_state.lock = '0;
          end
        end
        OFS_PW_INT_STATUS: next_state.pwis = state.pwis & reg_wdata;
        default: ;
      endcase
    end

    // hardware sets, winning over a same-cycle clear
    if (rx_bad_destid) begin
      next_state.led[ILLEGAL_TGT_BIT] = 1'b1;
    end
    if (state.rt_exp) begin
      next_state.led[RESP_TO_FLAG_BIT] = 1'b1;
    end
    if (doorbell_resp_timeout) begin
      next_state.pwis[PW_PENDING_BIT] = 1'b1;
    end
    if (state.ttl_exp) begin
      next_state.physical_link_configuration[OB_DRAIN_BIT] = 1'b1;
    end

    // lock-once capture, message unit blocked by any lock
    for (int s = 0; s < NUM_SRC; s++) begin
      if (err_event[s] && (state.lee != ZERO32) && !state.lock[s] &&
          ((s != SRC_MSG_UNIT) || !lock_any)) begin
        next_state.lock[s]      = 1'b1;
        next_state.cap_addr[s]  = err_addr[s];
        next_state.cap_devid[s] = err_devid[s];
        next_state.cap_ctrl[s]  = err_ctrl[s];
        next_state.cap_eci[s]   = err_char_is_ctrl[s];
      end
    end

    // register reads, data one cycle later
    unique case (reg_addr)
      OFS_LINK_TIMEOUT:  rd_val[TO_VAL_LSB +: CNT_W] = state.lto_val;
      OFS_RESP_TIMEOUT:  rd_val[TO_VAL_LSB +: CNT_W] = state.rto_val;
      OFS_TTL_CONFIG:    rd_val[TO_VAL_LSB +: CNT_W] = state.ttl_val;
      OFS_GEN_CTRL:      rd_val = state.gcs;
      OFS_LOCAL_ACK:     rd_val = state.ack;
      OFS_ERR_DETECT:    rd_val = state.led;
      OFS_ERR_ENABLE:    rd_val = state.lee;
      OFS_PW_INT_STATUS: rd_val = state.pwis;
      OFS_ACCEPT_ALL:    rd_val = state.accept_all_configuration;
      OFS_PHY_LINK_CFG:  rd_val = state.physical_link_configuration;
      default: begin
        for (int s = 0; s < NUM_SRC; s++) begin
          if (reg_addr == OFS_CAP_ADDR[s]) begin
            rd_val = state.cap_addr[s];
          end
          if (reg_addr == OFS_CAP_DEVID[s]) begin
            rd_val = state.cap_devid[s];
          end
          if (reg_addr == OFS_CAP_CTRL[s]) begin
            rd_val = state.cap_ctrl[s];
          end
          if (reg_addr == OFS_CAP_EXT[s]) begin
            rd_val[ECI_LSB +: 16] = state.cap_eci[s];
          end
        end
      end
    endcase
    next_state.rdata = reg_rd ? rd_val : ZERO32;

    if (srst) begin
      next_state         = '0;
      next_state.lto_val = TO_RESET;
      next_state.rto_val = TO_RESET;
      next_state.ttl_val = TTL_RESET;
      next_state.accept_all_configuration    = ACCEPT_ALL_RESET;
      next_state.physical_link_configuration     = PHY_CFG_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    state <= next_state;
  end

  assign reg_rdata             = state.rdata;
  assign link_timeout          = state.lt_exp;
  assign resp_timeout          = state.rt_exp;
  assign ttl_discard           = state.ttl_exp;
  assign internal_err_resp     = state.ie_exp;
  assign outbound_drain_enable = state.physical_link_configuration[OB_DRAIN_BIT];
  assign capture_locked        = state.lock;
  assign ext_ack_status        = state.ack;
endmodule // slt_timeouts

// >>> slt_link_partner.sv
// Purpose: far-side link partner answering each start after a set delay
// Assumes: lanes are ack, link-response, response, packet accept
// Notes:   mute withholds the answer to every start seen while it is high; answers are one-cycle pulses
`timescale 1ns/1ps
module slt_link_partner (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       mute,
  input  wire logic [7:0] delay,
  input  wire logic [3:0] start,
  output logic      [3:0] answer
);
  logic [3:0][7:0] cnt;

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      answer[i] <= (cnt[i] == 8'h01); // answer only once delay has run
      if (srst) begin
        cnt[i] <= 8'h00;
      end else if (start[i] && !mute) begin
        cnt[i] <= delay;
      end else if (cnt[i] != 8'h00) begin
        cnt[i] <= cnt[i] - 8'h01;
      end
    end
  end
endmodule // slt_link_partner

// >>> slt_timeouts_assertions.sv
// Purpose: port checks for timers and error capture
// Assumes: one clk_sys domain, srst synchronous active high
// Notes:   bound to every slt_timeouts instance
`timescale 1ns/1ps
module slt_timeouts_assertions (
  input wire logic                               clk_sys,
  input wire logic                               srst,
  input wire logic [slt_pkg::ADDR_W-1:0]         reg_addr,
  input wire logic                               reg_wr,
  input wire logic                               reg_rd,
  input wire logic [31:0]                        reg_rdata,
  input wire logic                               ack_rcvd,
  input wire logic                               pkt_sent,
  input wire logic [slt_pkg::ACK_W-1:0]          tx_ackid,
  input wire logic [slt_pkg::ACK_W-1:0]          rx_ackid,
  input wire logic [slt_pkg::NUM_SRC-1:0]        err_event,
  input wire logic [slt_pkg::NUM_LINK_EV-1:0]    link_timeout,
  input wire logic                               resp_timeout,
  input wire logic                               ttl_discard,
  input wire logic                               outbound_drain_enable,
  input wire logic [slt_pkg::NUM_SRC-1:0]        capture_locked,
  input wire logic [31:0]                        ext_ack_status
);
  import slt_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == ZERO32)
    else $error("read data not zero outside read cycle");
  chk_link_pulse: assert property (link_timeout[0] |=> !link_timeout[0])
    else $error("link expiry longer than one cycle");
  chk_link_stop: assert property ((ack_rcvd && !pkt_sent) |=> !link_timeout[0] [*4])
    else $error("link expiry after acknowledge");
  chk_resp_pulse: assert property (resp_timeout |=> !resp_timeout)
    else $error("response expiry longer than one cycle");
  chk_drain_set: assert property (ttl_discard |-> ##[1:2] outbound_drain_enable)
    else $error("drain enable not set after discard");
  chk_drain_cause: assert property ($rose(outbound_drain_enable) |->
    ($past(ttl_discard) || $past(ttl_discard, 2) || $past(reg_wr)))
    else $error("drain enable set without cause");
  chk_mu_guard: assert property ($rose(capture_locked[1]) |-> !$past(capture_locked[0]))
    else $error("message unit locked over port lock");
  chk_lock_cause: assert property ($rose(capture_locked[0]) |-> $past(err_event[0]))
    else $error("port capture locked without error");
  chk_lock_hold: assert property ((capture_locked[0] &&
    !(reg_wr && reg_addr == OFS_ERR_DETECT)) |=> capture_locked[0])
    else $error("port capture lock lost");
  chk_ack_mirror: assert property ((!$past(srst) && !$past(srst, 2)) |->
    (ext_ack_status[4:0] == $past(tx_ackid) &&
     ext_ack_status[28:24] == $past(rx_ackid)))
    else $error("external ack status mismatch");
endmodule // slt_timeouts_assertions

bind slt_timeouts slt_timeouts_assertions chk_inst (
  .clk_sys, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .ack_rcvd, .pkt_sent,
  .tx_ackid, .rx_ackid, .err_event, .link_timeout, .resp_timeout, .ttl_discard,
  .outbound_drain_enable, .capture_locked, .ext_ack_status
);

// >>> serial_link_timeouts_and_error_capture_tb_top.sv
// Purpose: register-level tests of timers and error capture
// Assumes: partner answers link events after a set delay
// Notes:   time-out values kept small so counts stay short
`timescale 1ns/1ps
module serial_link_timeouts_and_error_capture_tb_top;
  import slt_pkg::*;
  logic srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pkt_needs_resp = 1'b0, mute = 1'b1;
  logic clk_sys;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, ext_ack_status;
  logic [7:0] ev = 8'h00, delay = 8'h03;
  logic [ACK_W-1:0] tx_ackid = '0, rx_ackid = '0;
  logic [NUM_SRC-1:0][31:0] err_addr = '0, err_devid = '0, err_ctrl = '0;
  logic [NUM_SRC-1:0][15:0] err_char_is_ctrl = '0;
  logic [NUM_LINK_EV-1:0] link_timeout;
  logic [NUM_SRC-1:0] capture_locked, err_event;
  logic resp_timeout, ttl_discard, internal_err_resp, outbound_drain_enable;
  logic pkt_sent, link_req_sent, req_sent, pkt_ready, doorbell_resp_timeout, rx_bad_destid;
  logic ack_rcvd, link_resp_rcvd, resp_rcvd, pkt_accept;
  wire [3:0] answer;
  wire [4:0] outs = {internal_err_resp, ttl_discard, resp_timeout, link_timeout};
  int miscompares = 0, n_tests = 0;

  assign {err_event, rx_bad_destid, doorbell_resp_timeout, pkt_ready, req_sent, link_req_sent,
          pkt_sent} = ev;
  assign {pkt_accept, resp_rcvd, link_resp_rcvd, ack_rcvd} = answer;

  slt_timeouts DUT (
    .clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pkt_sent,
    .ack_rcvd, .link_req_sent, .link_resp_rcvd, .req_sent, .resp_rcvd, .pkt_ready,
    .pkt_accept, .pkt_needs_resp, .doorbell_resp_timeout, .rx_bad_destid, .tx_ackid,
    .rx_ackid, .err_event, .err_addr, .err_devid, .err_ctrl, .err_char_is_ctrl,
    .link_timeout, .resp_timeout, .ttl_discard, .internal_err_resp,
    .outbound_drain_enable, .capture_locked, .ext_ack_status
  );
  slt_link_partner partner (.clk_sys, .srst, .mute, .delay, .start(ev[3:0]), .answer);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev[i] <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // lo of zero means no pulse may appear within hi cycles
  task automatic expect_pulse(input int w, input int lo, input int hi);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (n < hi && !hit) begin
      @(posedge clk_sys);
      #1;
      n++;
      hit = (outs[w] === 1'b1);
    end
    chk({31'h0, hit && n >= lo}, {31'h0, lo > 0});
  endtask

  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd(OFS_LINK_TIMEOUT, 32'hFFFFFF00);
    rd(OFS_RESP_TIMEOUT, 32'hFFFFFF00);
    rd(OFS_ACCEPT_ALL, 32'h10000000);
    rd(OFS_PHY_LINK_CFG, 32'h00000010);
    rd(OFS_TTL_CONFIG, ZERO32);
    rd(24'h000100, ZERO32);
    wr(OFS_GEN_CTRL, 32'hFFFFFFFF);
    rd(OFS_GEN_CTRL, 32'hE0000000);
    wr(OFS_LINK_TIMEOUT, 32'h00000400);
    for (int i = 0; i < 2; i++) begin
      pulse(i);
      expect_pulse(i, 8, 14);
    end
    mute <= 1'b0;
    pulse(0);
    expect_pulse(0, 0, 40);
    mute <= 1'b1;
    wr(OFS_RESP_TIMEOUT, 32'h00000100);
    pulse(2);
    expect_pulse(2, 61, 120);
    wr(OFS_TTL_CONFIG, 32'h00000600);
    pkt_needs_resp <= 1'b1;
    pulse(3);
    expect_pulse(3, 12, 20);
    settle;
    chk({31'h0, outbound_drain_enable}, 32'h1);
    expect_pulse(4, 58, 118);
    rd(OFS_PHY_LINK_CFG, 32'h00000014);
    wr(OFS_PHY_LINK_CFG, 32'h00000010);
    rd(OFS_PHY_LINK_CFG, 32'h00000010);
    chk({31'h0, outbound_drain_enable}, 32'h0);
    mute <= 1'b0;
    pulse(3);
    expect_pulse(3, 0, 40);
    pulse(5);
    rd(OFS_ERR_DETECT, 32'h04000000, 32'h04000000);
    pulse(4);
    rd(OFS_PW_INT_STATUS, 32'h80000000);
    @(posedge clk_sys);
    err_addr <= {32'h0000B002, 32'h0000A001};
    err_devid <= {32'h000000D2, 32'h000000C1};
    err_ctrl <= {32'h0F000000, 32'h0E000000};
    err_char_is_ctrl <= {16'h5AA5, 16'hBEEF};
    pulse(6);
    settle;
    chk({30'h0, capture_locked}, 32'h0);
    wr(OFS_ERR_ENABLE, 32'h00000001);
    pulse(6);
    settle;
    chk({30'h0, capture_locked}, 32'h1);
    @(posedge clk_sys);
    err_addr[0] <= 32'h0000A0FF;
    pulse(6);
    pulse(7);
    settle;
    chk({30'h0, capture_locked}, 32'h1);
    rd(OFS_CAP_ADDR[0], 32'h0000A001);
    rd(OFS_CAP_DEVID[0], 32'h000000C1);
    rd(OFS_CAP_CTRL[0], 32'h0E000000);
    rd(OFS_CAP_EXT[0], 32'h00BEEF00, 32'h00FFFF00);
    rd(OFS_CAP_ADDR[1], ZERO32);
    wr(OFS_ERR_DETECT, ZERO32);
    pulse(7);
    settle;
    chk({30'h0, capture_locked}, 32'h2);
    rd(OFS_CAP_DEVID[1], 32'h000000D2);
    rd(OFS_CAP_CTRL[1], 32'h0F000000);
    rd(OFS_CAP_ADDR[1], 32'h0000B002);
    rd(OFS_CAP_EXT[1], 32'h005AA500, 32'h00FFFF00);
    @(posedge clk_sys);
    tx_ackid <= 5'h0A;
    rx_ackid <= 5'h13;
    rd(OFS_LOCAL_ACK, 32'h1300000A, 32'h1F00001F);
    chk(ext_ack_status & 32'h1F00001F, 32'h1300000A);
    give_verdict;
  end
endmodule // serial_link_timeouts_and_error_capture_tb_top
